// [hw/uc_pkg.sv]
/*
  Shared constants and carriers for the UART interrupt identify and FIFO setup block.
  Assumes one clock domain; register accesses arrive as single-cycle strobes from the host bridge.
*/

package uc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] UC_OFS_DIV_HIGH   = 3'h1;
  localparam logic [2:0] UC_OFS_IDENT      = 3'h2;
  localparam logic [7:0] UC_FMT_ENH_ACCESS = 8'hbf;
  localparam int         UC_FMT_DIV_BIT    = 7;
  localparam logic [7:0] UC_DIV_HIGH_RST   = 8'h00;
  localparam logic [7:0] UC_IDENT_RST      = 8'h01;
  localparam logic [7:0] UC_RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Setup fields
  // ----------------------------------------------------------------
  localparam int UC_SET_EN_BIT    = 0;
  localparam int UC_SET_RXRST_BIT = 1;
  localparam int UC_SET_TXRST_BIT = 2;
  localparam int UC_SET_TXTRG_LSB = 4;
  localparam int UC_SET_RXTRG_LSB = 6;

  // ----------------------------------------------------------------
  // Trigger thresholds
  // ----------------------------------------------------------------
  localparam logic [6:0] UC_RX_TH0 = 7'h08;
  localparam logic [6:0] UC_RX_TH1 = 7'h10;
  localparam logic [6:0] UC_RX_TH2 = 7'h38;
  localparam logic [6:0] UC_RX_TH3 = 7'h3c;
  localparam logic [6:0] UC_TX_TH0 = 7'h08;
  localparam logic [6:0] UC_TX_TH1 = 7'h10;
  localparam logic [6:0] UC_TX_TH2 = 7'h20;
  localparam logic [6:0] UC_TX_TH3 = 7'h38;
  localparam logic [6:0] UC_TH_NOFIFO = 7'h01;
  localparam logic [6:0] UC_FIFO_DEPTH = 7'h40;

  // ----------------------------------------------------------------
  // Identify codes, bits 5..0
  // ----------------------------------------------------------------
  localparam logic [5:0] UC_ID_NONE    = 6'h01;
  localparam logic [5:0] UC_ID_LINE    = 6'h06;
  localparam logic [5:0] UC_ID_TIMEOUT = 6'h0c;
  localparam logic [5:0] UC_ID_RXDATA  = 6'h04;
  localparam logic [5:0] UC_ID_TXRDY   = 6'h02;
  localparam logic [5:0] UC_ID_MODEM   = 6'h00;
  localparam logic [5:0] UC_ID_PIN     = 6'h30;
  localparam logic [5:0] UC_ID_XOFF    = 6'h10;
  localparam logic [5:0] UC_ID_HSK     = 6'h20;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uc_reg_req_s;

  typedef struct packed {
    logic line_err;
    logic rx_timeout;
    logic rx_data;
    logic tx_ready;
    logic modem;
    logic pin_change;
    logic xoff_spec;
    logic hsk_inactive;
  } uc_irq_src_s;

endpackage

// [hw/uc_trigger.sv]
/*
  Registered FIFO trigger compare with a four-entry threshold table.
  Assumes the level input counts characters (receive) or free spaces (transmit).
*/
`timescale 1ns/100ps
`default_nettype none

module uc_trigger #(
  parameter logic [6:0] TH0 = 7'h08,
  parameter logic [6:0] TH1 = 7'h10,
  parameter logic [6:0] TH2 = 7'h20,
  parameter logic [6:0] TH3 = 7'h38
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       fifo_en_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [6:0] level_i,
  output var  logic       hit_o
);

  logic [6:0] thresh;

  always_comb begin
    case (sel_i)
      2'h0:    thresh = TH0;
      2'h1:    thresh = TH1;
      2'h2:    thresh = TH2;
      default: thresh = TH3;
    endcase
    // One-character holding register when FIFOs are off
    if (!fifo_en_i) begin
      thresh = uc_pkg::UC_TH_NOFIFO;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= (level_i >= thresh);
    end
  end

endmodule

`default_nettype wire

// [hw/uc_ident_prio.sv]
/*
  Priority encoder for the interrupt identify code, bits 5..0.
  Assumes sources arrive already gated by their enables.
*/
`timescale 1ns/100ps
`default_nettype none

module uc_ident_prio (
  input  wire uc_pkg::uc_irq_src_s src_i,
  output var  logic [5:0]          code_o
);

  always_comb begin
    if (src_i.line_err) begin
      code_o = uc_pkg::UC_ID_LINE;
    end else if (src_i.rx_timeout) begin
      code_o = uc_pkg::UC_ID_TIMEOUT;
    end else if (src_i.rx_data) begin
      code_o = uc_pkg::UC_ID_RXDATA;
    end else if (src_i.tx_ready) begin
      code_o = uc_pkg::UC_ID_TXRDY;
    end else if (src_i.modem) begin
      code_o = uc_pkg::UC_ID_MODEM;
    end else if (src_i.pin_change) begin
      code_o = uc_pkg::UC_ID_PIN;
    end else if (src_i.xoff_spec) begin
      code_o = uc_pkg::UC_ID_XOFF;
    end else if (src_i.hsk_inactive) begin
      code_o = uc_pkg::UC_ID_HSK;
    end else begin
      code_o = uc_pkg::UC_ID_NONE;
    end
  end

endmodule

`default_nettype wire

// [hw/uc_ident_fifo_ctrl.sv]
/*
  Per-channel divisor high byte, interrupt identify and FIFO setup registers.
  Assumes the host bridge presents one-cycle read/write strobes with a 3-bit offset,
  the line format and enhanced feature registers live elsewhere and are given as inputs,
  and all interrupt sources but receive data, transmit ready and special character match, gated here, are already enabled by their own enable bits.
*/
`timescale 1ns/100ps
`default_nettype none

module uc_ident_fifo_ctrl (
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                soft_rst_i,
  input  wire uc_pkg::uc_reg_req_s req_i,
  input  wire logic [7:0]          line_format_control_i,
  input  wire logic                enh_enable_i,
  input  wire logic                spec_detect_en_i,
  input  wire logic                line_err_i,
  input  wire logic                rx_timeout_i,
  input  wire logic                rx_data_int_en_i,
  input  wire logic                tx_ready_int_en_i,
  input  wire logic                modem_i,
  input  wire logic                pin_change_i,
  input  wire logic                xoff_i,
  input  wire logic                spec_char_i,
  input  wire logic                hsk_inactive_i,
  input  wire logic [6:0]          rx_level_i,
  input  wire logic [6:0]          tx_level_i,
  output logic [7:0]               rdata_o,
  output logic [7:0]               divisor_high_byte_o,
  output logic                     fifo_enable_o,
  output logic                     tx_fifo_flush_o,
  output logic                     rx_fifo_flush_o,
  output logic                     rx_trigger_o,
  output logic                     tx_trigger_o,
  output logic                     irq_pending_o
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] div_high;
    logic       fifo_en;
    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic       tx_rst;
    logic       rx_rst;
    logic [7:0] ident;
    logic [7:0] rdata;
  } uc_state_s;

  localparam uc_state_s UC_STATE_RST = '{
    div_high: uc_pkg::UC_DIV_HIGH_RST,
    fifo_en:  1'b0,
    rx_sel:   2'h0,
    tx_sel:   2'h0,
    tx_rst:   1'b0,
    rx_rst:   1'b0,
    ident:    uc_pkg::UC_IDENT_RST,
    rdata:    8'h00
  };

  uc_state_s state_r;
  uc_state_s state_nxt;

  // ----------------------------------------------------------------
  // Trigger compares and identify priority
  // ----------------------------------------------------------------
  logic                rx_hit;
  logic                tx_hit;
  logic [6:0]          tx_free;
  logic [5:0]          id_code;
  uc_pkg::uc_irq_src_s src;

  // Free spaces; non-FIFO mode holds a single character
  always_comb begin
    if (state_r.fifo_en) begin
      tx_free = uc_pkg::UC_FIFO_DEPTH - tx_level_i;
    end else begin
      tx_free = uc_pkg::UC_TH_NOFIFO - tx_level_i;
    end
  end

  uc_trigger #(
    .TH0 (uc_pkg::UC_RX_TH0),
    .TH1 (uc_pkg::UC_RX_TH1),
    .TH2 (uc_pkg::UC_RX_TH2),
    .TH3 (uc_pkg::UC_RX_TH3)
  ) u_rx_trig (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_sync_r),
    .fifo_en_i  (state_r.fifo_en),
    .sel_i      (state_r.rx_sel),
    .level_i    (rx_level_i),
    .hit_o      (rx_hit)
  );

  uc_trigger #(
    .TH0 (uc_pkg::UC_TX_TH0),
    .TH1 (uc_pkg::UC_TX_TH1),
    .TH2 (uc_pkg::UC_TX_TH2),
    .TH3 (uc_pkg::UC_TX_TH3)
  ) u_tx_trig (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_sync_r),
    .fifo_en_i  (state_r.fifo_en),
    .sel_i      (state_r.tx_sel),
    .level_i    (tx_free),
    .hit_o      (tx_hit)
  );

  always_comb begin
    src.line_err     = line_err_i;
    src.rx_timeout   = rx_timeout_i;
    src.rx_data      = rx_hit & rx_data_int_en_i;
    src.tx_ready     = tx_hit & tx_ready_int_en_i;
    src.modem        = modem_i;
    src.pin_change   = pin_change_i;
    // Special match only counts while detection is on
    src.xoff_spec    = xoff_i | (spec_char_i & spec_detect_en_i);
    src.hsk_inactive = hsk_inactive_i;
  end

  uc_ident_prio u_prio (
    .src_i  (src),
    .code_o (id_code)
  );

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  logic div_access;
  logic div_sel;
  logic id_sel;

  always_comb begin
    div_access = line_format_control_i[uc_pkg::UC_FMT_DIV_BIT];
    div_sel    = div_access && (line_format_control_i != uc_pkg::UC_FMT_ENH_ACCESS)
                 && (req_i.addr == uc_pkg::UC_OFS_DIV_HIGH);
    id_sel     = !div_access && (req_i.addr == uc_pkg::UC_OFS_IDENT);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;

    // Flush requests last exactly one cycle
    state_nxt.tx_rst = 1'b0;
    state_nxt.rx_rst = 1'b0;

    if (req_i.wr && div_sel) begin
      state_nxt.div_high = req_i.wdata;
    end

    if (req_i.wr && id_sel) begin
      state_nxt.fifo_en = req_i.wdata[uc_pkg::UC_SET_EN_BIT];
      // Other setup bits only land while the FIFO enable is written high
      if (req_i.wdata[uc_pkg::UC_SET_EN_BIT]) begin
        state_nxt.rx_sel = req_i.wdata[uc_pkg::UC_SET_RXTRG_LSB +: 2];
        if (enh_enable_i) begin
          state_nxt.tx_sel = req_i.wdata[uc_pkg::UC_SET_TXTRG_LSB +: 2];
        end
        state_nxt.tx_rst = req_i.wdata[uc_pkg::UC_SET_TXRST_BIT];
        state_nxt.rx_rst = req_i.wdata[uc_pkg::UC_SET_RXRST_BIT];
      end
    end

    state_nxt.ident = {{2{state_nxt.fifo_en}}, id_code};

    if (req_i.rd && id_sel) begin
      state_nxt.rdata = state_r.ident;
    end else if (req_i.rd && div_sel) begin
      state_nxt.rdata = state_r.div_high;
    end else if (req_i.rd) begin
      state_nxt.rdata = uc_pkg::UC_RDATA_UNMAPPED;
    end

    // Software reset spares the divisor byte
    if (soft_rst_i) begin
      state_nxt          = UC_STATE_RST;
      state_nxt.div_high = state_r.div_high;
    end
  end

  // Power-on reset is the only path that clears the divisor
  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= UC_STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    rdata_o             = state_r.rdata;
    divisor_high_byte_o = state_r.div_high;
    fifo_enable_o       = state_r.fifo_en;
    tx_fifo_flush_o     = state_r.tx_rst;
    rx_fifo_flush_o     = state_r.rx_rst;
    rx_trigger_o        = rx_hit;
    tx_trigger_o        = tx_hit;
    irq_pending_o       = !state_r.ident[0];
  end

endmodule

`default_nettype wire

// [verification/uc_ident_fifo_ctrl_asserts.sv]
/*
  Port-level checks for the identify, divisor and FIFO setup block.
  Assumes one clock; checks wait out the two-flop reset release.
*/
`timescale 1ns/100ps
`default_nettype none

module uc_ident_fifo_ctrl_asserts (
  input wire logic                core_clk_i,
  input wire logic                rst_n_i,
  input wire logic                soft_rst_i,
  input wire uc_pkg::uc_reg_req_s req_i,
  input wire logic [7:0]          line_format_control_i,
  input wire logic                line_err_i,
  input wire logic                rx_timeout_i,
  input wire logic                modem_i,
  input wire logic                pin_change_i,
  input wire logic                xoff_i,
  input wire logic                hsk_inactive_i,
  input wire logic [6:0]          rx_level_i,
  input wire logic [7:0]          rdata_o,
  input wire logic [7:0]          divisor_high_byte_o,
  input wire logic                fifo_enable_o,
  input wire logic                tx_fifo_flush_o,
  input wire logic                rx_fifo_flush_o,
  input wire logic                rx_trigger_o,
  input wire logic                irq_pending_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic       dl;
  logic       wr_set;
  logic       wr_div;
  logic       rd_div;
  logic       rd_id;
  logic [1:0] up_r;

  assign dl     = line_format_control_i[7];
  assign wr_set = req_i.wr && req_i.addr == 3'h2 && !dl && !soft_rst_i;
  // Software reset wins over a same-cycle access
  assign wr_div = req_i.wr && req_i.addr == 3'h1 && dl && line_format_control_i != 8'hbf && !soft_rst_i;
  assign rd_div = req_i.rd && !req_i.wr && req_i.addr == 3'h1 && dl && line_format_control_i != 8'hbf
                  && !soft_rst_i;
  assign rd_id  = req_i.rd && req_i.addr == 3'h2 && !dl;

  // Internal reset lags the pin by two edges, so hold checks off until then
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i || up_r != 2'h3);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_pend_direct: assert property ((line_err_i || rx_timeout_i || modem_i || pin_change_i
    || xoff_i || hsk_inactive_i) && !soft_rst_i |=> irq_pending_o)
    else $error("pending flag missing after source");
  chk_tx_flush: assert property (wr_set && req_i.wdata[0] && req_i.wdata[2]
    |=> tx_fifo_flush_o ##1 !tx_fifo_flush_o)
    else $error("tx flush not a single pulse");
  chk_rx_flush: assert property (wr_set && req_i.wdata[0] && req_i.wdata[1]
    |=> rx_fifo_flush_o ##1 !rx_fifo_flush_o)
    else $error("rx flush not a single pulse");
  chk_flush_cause: assert property ($rose(tx_fifo_flush_o) |-> $past(wr_set && req_i.wdata[2]))
    else $error("tx flush without a write");
  chk_fifo_write: assert property (wr_set |=> fifo_enable_o == $past(req_i.wdata[0]))
    else $error("fifo enable not taken from write");
  chk_setup_gated: assert property (req_i.wr && req_i.addr == 3'h2 && dl && !soft_rst_i
    |=> $stable(fifo_enable_o))
    else $error("setup written with divisor access open");
  chk_div_write: assert property (wr_div |=> divisor_high_byte_o == $past(req_i.wdata))
    else $error("divisor byte not written");
  chk_div_hold: assert property (!wr_div |=> $stable(divisor_high_byte_o))
    else $error("divisor byte changed without write");
  chk_div_read: assert property (rd_div ##1 (!req_i.rd && !wr_div && !soft_rst_i)
    |=> rdata_o == divisor_high_byte_o)
    else $error("divisor read data wrong");
  chk_ident_mirror: assert property ((!req_i.wr && !soft_rst_i)[*3] ##0 rd_id
    ##1 (!req_i.rd && !req_i.wr && !soft_rst_i) |=> rdata_o[7:6] == {2{fifo_enable_o}})
    else $error("identify top bits not mirroring enable");
  chk_rx_nofifo: assert property ((!fifo_enable_o && rx_level_i != 7'h00 && !soft_rst_i)[*3]
    |=> rx_trigger_o)
    else $error("rx trigger not one character");
endmodule

bind uc_ident_fifo_ctrl uc_ident_fifo_ctrl_asserts u_chk (.core_clk_i, .rst_n_i, .soft_rst_i, .req_i,
  .line_format_control_i, .line_err_i, .rx_timeout_i, .modem_i, .pin_change_i, .xoff_i, .hsk_inactive_i,
  .rx_level_i, .rdata_o, .divisor_high_byte_o, .fifo_enable_o, .tx_fifo_flush_o, .rx_fifo_flush_o,
  .rx_trigger_o, .irq_pending_o);

`default_nettype wire

// [verification/uc_host_model.sv]
/*
  Host side of the register strobe bus: one byte per transfer.
  Assumes read data holds from one edge after the strobe until the next read.
*/
`timescale 1ns/100ps
`default_nettype none

module uc_host_model (
  input  wire logic                core_clk_i,
  input  wire logic [7:0]          rdata_i,
  output var  uc_pkg::uc_reg_req_s req_o
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial req_o = '0;

  // Strobe drops for a cycle between transfers so two never merge
  task automatic put(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    req_o = {w, !w, a, d};
    @(posedge core_clk_i);
    #1;
    req_o = '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    put(1'b0, a, 8'h00);
    @(posedge core_clk_i);
    #1;
    d = rdata_i;
  endtask
endmodule

`default_nettype wire

// [verification/uc_ident_fifo_ctrl_tb_top.sv]
/*
  Self-checking bench: identify priorities, setup fields, flushes and divisor resets.
  Assumes the host model and checker compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`define UC_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s: expected %h, seen %h", nm, e, g); end end

module uc_ident_fifo_ctrl_tb_top;
  logic                core_clk_i, rst_n_i, soft_rst_i, enh_enable_i, spec_detect_en_i, spec_char_i;
  logic [7:0]          fmt, src, rdata_o, divisor_high_byte_o, v;
  logic [6:0]          rx_level_i, tx_level_i;
  logic                fifo_enable_o, tx_fifo_flush_o, rx_fifo_flush_o, rx_trigger_o, tx_trigger_o;
  logic                irq_pending_o;
  uc_pkg::uc_reg_req_s req;
  int                  error_cnt = 0;
  int                  num_checks = 0;
  logic [7:0]          codes [8] = '{8'h06, 8'h0c, 8'h04, 8'h02, 8'h00, 8'h30, 8'h10, 8'h20};
  logic [6:0]          rx_th [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};
  logic [6:0]          tx_th [4] = '{7'h08, 7'h10, 7'h20, 7'h38};

  uc_host_model host (.core_clk_i(core_clk_i), .rdata_i(rdata_o), .req_o(req));

  uc_ident_fifo_ctrl DUT (.core_clk_i, .rst_n_i, .soft_rst_i, .req_i(req), .line_format_control_i(fmt),
    .enh_enable_i, .spec_detect_en_i, .line_err_i(src[7]), .rx_timeout_i(src[6]), .rx_data_int_en_i(src[5]),
    .tx_ready_int_en_i(src[4]), .modem_i(src[3]), .pin_change_i(src[2]), .xoff_i(src[1]), .spec_char_i,
    .hsk_inactive_i(src[0]), .rx_level_i, .tx_level_i, .rdata_o, .divisor_high_byte_o, .fifo_enable_o,
    .tx_fifo_flush_o, .rx_fifo_flush_o, .rx_trigger_o, .tx_trigger_o, .irq_pending_o);

  // ----------------------------------------------------------------
  // Clock, helpers, verdict
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    error_cnt++;
    final_report;
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, soft_rst_i, enh_enable_i, spec_detect_en_i, spec_char_i} = '0;
    {fmt, src, rx_level_i, tx_level_i} = '0;
    repeat (4) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    cyc(3);
    host.rd(3'h2, v);
    `UC_CHK("identify", 8'h01, v)
    `UC_CHK("pending", 1'b0, irq_pending_o)
    fmt = 8'h80;
    host.rd(3'h1, v);
    `UC_CHK("divisor", 8'h00, v)
    host.put(1'b1, 3'h1, 8'ha5);
    host.put(1'b1, 3'h2, 8'h01);
    `UC_CHK("fifo_enable", 1'b0, fifo_enable_o)
    fmt = 8'hbf;
    host.put(1'b1, 3'h1, 8'h3c);
    fmt = 8'h80;
    host.rd(3'h1, v);
    `UC_CHK("divisor", 8'ha5, v)
    fmt = 8'h00;
    rx_level_i = 7'h01;
    for (int i = 0; i < 8; i++) begin
      src = 8'hff >> i;
      cyc(4);
      host.rd(3'h2, v);
      `UC_CHK("identify", codes[i], v)
    end
    src = 8'h00;
    spec_char_i = 1'b1;
    cyc(4);
    host.rd(3'h2, v);
    `UC_CHK("identify", 8'h01, v)
    spec_detect_en_i = 1'b1;
    cyc(4);
    host.rd(3'h2, v);
    `UC_CHK("identify", 8'h10, v)
    {spec_char_i, spec_detect_en_i, rx_level_i} = '0;
    enh_enable_i = 1'b1;
    host.put(1'b1, 3'h2, 8'h07);
    `UC_CHK("tx_flush", 1'b1, tx_fifo_flush_o)
    `UC_CHK("rx_flush", 1'b1, rx_fifo_flush_o)
    cyc(1);
    `UC_CHK("tx_flush", 1'b0, tx_fifo_flush_o)
    `UC_CHK("rx_flush", 1'b0, rx_fifo_flush_o)
    src = 8'h01;
    cyc(4);
    host.rd(3'h2, v);
    `UC_CHK("identify", 8'he0, v)
    `UC_CHK("pending", 1'b1, irq_pending_o)
    src = 8'h00;
    // Each level sits one below, then exactly at, the selected threshold
    for (int s = 0; s < 4; s++) begin
      host.put(1'b1, 3'h2, {s[1:0], s[1:0], 4'h1});
      rx_level_i = rx_th[s] - 7'h01;
      tx_level_i = 7'h41 - tx_th[s];
      cyc(3);
      `UC_CHK("rx_trigger", 1'b0, rx_trigger_o)
      `UC_CHK("tx_trigger", 1'b0, tx_trigger_o)
      rx_level_i = rx_th[s];
      tx_level_i = 7'h40 - tx_th[s];
      cyc(3);
      `UC_CHK("rx_trigger", 1'b1, rx_trigger_o)
      `UC_CHK("tx_trigger", 1'b1, tx_trigger_o)
    end
    enh_enable_i = 1'b0;
    host.put(1'b1, 3'h2, 8'h01);
    tx_level_i = 7'h09;
    rx_level_i = 7'h08;
    cyc(3);
    `UC_CHK("tx_trigger", 1'b0, tx_trigger_o)
    `UC_CHK("rx_trigger", 1'b1, rx_trigger_o)
    host.put(1'b1, 3'h2, 8'hc0);
    `UC_CHK("fifo_enable", 1'b0, fifo_enable_o)
    host.put(1'b1, 3'h2, 8'h06);
    `UC_CHK("tx_flush", 1'b0, tx_fifo_flush_o)
    tx_level_i = 7'h00;
    rx_level_i = 7'h01;
    cyc(4);
    `UC_CHK("rx_trigger", 1'b1, rx_trigger_o)
    rx_level_i = 7'h00;
    cyc(3);
    `UC_CHK("rx_trigger", 1'b0, rx_trigger_o)
    host.put(1'b1, 3'h2, 8'h01);
    soft_rst_i = 1'b1;
    cyc(1);
    soft_rst_i = 1'b0;
    `UC_CHK("divisor", 8'ha5, divisor_high_byte_o)
    `UC_CHK("fifo_enable", 1'b0, fifo_enable_o)
    rst_n_i = 1'b0;
    cyc(2);
    `UC_CHK("divisor", 8'h00, divisor_high_byte_o)
    rst_n_i = 1'b1;
    cyc(3);
    // Nonzero read data first, so an unmapped read that keeps old data is caught
    host.rd(3'h2, v);
    `UC_CHK("identify", 8'h01, v)
    host.rd(3'h7, v);
    `UC_CHK("unmapped", 8'h00, v)
    final_report;
  end
endmodule

`default_nettype wire
